// ===== hw/csd_pkg.sv
package csd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // opcode bytes
    localparam logic [7:0] OP_PREFIX_Y = 8'h18;
    localparam logic [7:0] OP_TEST = 8'h00;
    localparam logic [7:0] OP_TAP = 8'h06;
    localparam logic [7:0] OP_TPA = 8'h07;
    localparam logic [7:0] OP_TSX = 8'h30;
    localparam logic [7:0] OP_TXS = 8'h35;
    localparam logic [7:0] OP_WAI = 8'h3e;
    localparam logic [7:0] OP_ZERO_TEST_ACC_FIRST_OP = 8'h4d;
    localparam logic [7:0] OP_ZERO_TEST_ACC_SECOND_OP = 8'h5d;
    localparam logic [7:0] OP_TST_IDX = 8'h6d;
    localparam logic [7:0] OP_TST_EXT = 8'h7d;
    localparam logic [7:0] OP_XGD = 8'h8f;
    // subtract families: high nibble picks accumulator and mode
    localparam logic [3:0] OP_LO_SUB8 = 4'h0;
    localparam logic [3:0] OP_LO_SUB_DOUBLE_OP = 4'h3;
    localparam logic [3:0] HI_A_IMM = 4'h8;
    localparam logic [3:0] HI_A_DIR = 4'h9;
    localparam logic [3:0] HI_A_IDX = 4'ha;
    localparam logic [3:0] HI_A_EXT = 4'hb;
    localparam logic [3:0] HI_B_IMM = 4'hc;
    localparam logic [3:0] HI_B_DIR = 4'hd;
    localparam logic [3:0] HI_B_IDX = 4'he;
    localparam logic [3:0] HI_B_EXT = 4'hf;

    ////////////////////////////////////////////////////////////////////////
    // cycle counts of the unprefixed forms
    localparam logic [4:0] CYC_INH = 5'h02;
    localparam logic [4:0] CYC_XFER = 5'h03;
    localparam logic [4:0] CYC_IMM8 = 5'h02;
    localparam logic [4:0] CYC_DIR8 = 5'h03;
    localparam logic [4:0] CYC_EXT8 = 5'h04;
    localparam logic [4:0] CYC_IDX8 = 5'h04;
    localparam logic [4:0] CYC_IMM16 = 5'h04;
    localparam logic [4:0] CYC_DIR16 = 5'h05;
    localparam logic [4:0] CYC_EXT16 = 5'h06;
    localparam logic [4:0] CYC_IDX16 = 5'h06;
    localparam logic [4:0] CYC_TST_MEM = 5'h06;
    localparam logic [4:0] CYC_WAI_STACK = 5'h0c;
    localparam logic [4:0] PUSH_FIRST = 5'h01;
    localparam logic [4:0] PUSH_LAST = 5'h09;

    ////////////////////////////////////////////////////////////////////////
    // flag register bit positions and reset values
    localparam int FB_S = 7;
    localparam int FB_X = 6;
    localparam int FB_N = 3;
    localparam int FB_C = 0;
    localparam logic [7:0] RST_FLAGS = 8'hd0;
    localparam logic [7:0] RST_ACC = 8'h00;
    localparam logic [15:0] RST_REG16 = 16'h0000;
    localparam logic [15:0] RST_SP = 16'h00ff;
    localparam logic [15:0] VEC_WAI_ADDR = 16'hfff0;

    typedef enum logic [8:0] {
        ST_FETCH = 9'h001,
        ST_OPND = 9'h002,
        ST_MEM = 9'h004,
        ST_FILL = 9'h008,
        ST_WSTK = 9'h010,
        ST_WIDLE = 9'h020,
        ST_VEC = 9'h040,
        ST_TEST = 9'h080,
        ST_SPARE = 9'h100
    } csd_state_e;

    typedef enum logic [2:0] {MD_INH, MD_IMM, MD_DIR, MD_EXT, MD_IDX} csd_mode_e;

    typedef enum logic [3:0] {
        K_BAD, K_SUB_ACC_FIRST_OP, K_SUB_ACC_SECOND_OP, K_SUB_DOUBLE_OP, K_TAP, K_TPA, K_TST, K_ZERO_TEST_ACC_FIRST_OP, K_ZERO_TEST_ACC_SECOND_OP,
        K_TSX, K_TXS, K_XGD, K_WAI, K_TEST
    } csd_kind_e;

    typedef struct packed {
        csd_kind_e kind;
        csd_mode_e mode;
        logic wide;
        logic [4:0] cyc;
    } csd_dec_s;

endpackage

// ===== hw/csd_ag_if.sv
`timescale 1ns/10ps
`default_nettype none

// carries operand bytes to the address unit and its results back
interface csd_ag_if;
    import csd_pkg::*;
    csd_mode_e mode;
    logic [15:0] opnd;
    logic [15:0] index;
    logic second;
    logic [15:0] pc_next;
    logic [7:0] dat;
    logic [15:0] ea;
    logic [15:0] rel_target;
    logic [7:0] mask_set;

    modport core (output mode, opnd, index, second, pc_next, dat, input ea, rel_target, mask_set);
    modport agen (input mode, opnd, index, second, pc_next, dat, output ea, rel_target, mask_set);
endinterface

`default_nettype wire

// ===== hw/csd_agen.sv
`timescale 1ns/10ps
`default_nettype none

module csd_agen
    import csd_pkg::*;
(
    csd_ag_if.agen ag
);

    wire logic [15:0] base_w;

    ////////////////////////////////////////////////////////////////////////
    // effective address: direct, extended or unsigned-offset indexed
    assign base_w = (ag.mode == MD_DIR) ? {8'h00, ag.opnd[7:0]} :
                    (ag.mode == MD_EXT) ? ag.opnd :
                    (ag.mode == MD_IDX) ? ag.index + {8'h00, ag.opnd[7:0]} :
                    16'h0000;
    // second byte of a pair lives at the next address
    assign ag.ea = base_w + {15'h0000, ag.second};

    // signed offset from the byte after the offset byte
    assign ag.rel_target = ag.pc_next + {{8{ag.opnd[7]}}, ag.opnd[7:0]};
    // set bits of the mask mark the positions touched
    assign ag.mask_set = ag.dat | ag.opnd[7:0];

endmodule

`default_nettype wire

// ===== hw/csd_core.sv
// How it works
// - subtract memory from accumulator A, four modes, 2-5 cycles, sets NZVC.
// - subtract memory from accumulator B, four modes, 2-5 cycles, sets NZVC.
// - subtract 16-bit memory pair from double accumulator, sets NZVC.
// - opcode 06 copies A into flag register in 2 cycles.
// - opcode 07 copies flag register into A, flags untouched.
// - memory test sets N,Z from operand, clears V,C, stores nothing.
// - accumulator tests 4D/5D take 2 cycles, set N,Z, clear V,C.
// - stack pointer plus one loads the index register, flags untouched.
// - index register minus one loads the stack pointer, flags untouched.
// - opcode 00 in test mode increments the address bus, flags untouched.
// - the test instruction only ends by reset.
// - wait instruction pushes registers then waits, flags untouched.
// - wait uses 12 cycles, n idle cycles, two vector cycles.
// - direct address is the operand byte with zero high byte.
// - indexed address adds unsigned operand byte to the index register.
// - extended address bytes arrive high byte first.
// - 16-bit immediate data arrives high byte first.
// - relative offset is signed, added to address after offset byte.
// - mask operand set bits mark the bits affected.
// - a flag load may clear the X mask bit but never set it.
`timescale 1ns/10ps
`default_nettype none

module csd_core
    import csd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic test_mode_i,
    input wire logic irq_i,
    input wire logic [7:0] rdata_i,
    output logic [15:0] addr_o,
    output logic rd_o,
    output logic wr_o,
    output logic [7:0] wdata_o,
    output logic waiting_o,
    output logic testing_o,
    output logic unsupported_o,
    output logic [15:0] pc_o,
    output logic [7:0] acc_a_o,
    output logic [7:0] acc_b_o,
    output logic [15:0] ix_o,
    output logic [15:0] iy_o,
    output logic [15:0] sp_o,
    output logic [7:0] flags_o,
    output logic [15:0] rel_target_o,
    output logic [7:0] mask_set_o
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // opcode decode, prefixed forms cost one cycle more
    function automatic csd_dec_s csd_decode(input logic [7:0] op, input logic pre, input logic test_en);
        csd_dec_s d;
        csd_mode_e sm;
        d.kind = K_BAD;
        d.mode = MD_INH;
        d.wide = 1'b0;
        d.cyc = CYC_INH;
        case (op[7:4])
            HI_A_IMM, HI_B_IMM: sm = MD_IMM;
            HI_A_DIR, HI_B_DIR: sm = MD_DIR;
            HI_A_EXT, HI_B_EXT: sm = MD_EXT;
            HI_A_IDX, HI_B_IDX: sm = MD_IDX;
            default: sm = MD_INH;
        endcase
        if (sm != MD_INH && op[3:0] == OP_LO_SUB8) begin
            d.kind = op[6] ? K_SUB_ACC_SECOND_OP : K_SUB_ACC_FIRST_OP;
            d.mode = sm;
        end else if (sm != MD_INH && !op[6] && op[3:0] == OP_LO_SUB_DOUBLE_OP) begin
            d.kind = K_SUB_DOUBLE_OP;
            d.mode = sm;
            d.wide = 1'b1;
        end else begin
            case (op)
                OP_TAP: d.kind = K_TAP;
                OP_TPA: d.kind = K_TPA;
                OP_ZERO_TEST_ACC_FIRST_OP: d.kind = K_ZERO_TEST_ACC_FIRST_OP;
                OP_ZERO_TEST_ACC_SECOND_OP: d.kind = K_ZERO_TEST_ACC_SECOND_OP;
                OP_TST_EXT: begin
                    d.kind = K_TST;
                    d.mode = MD_EXT;
                end
                OP_TST_IDX: begin
                    d.kind = K_TST;
                    d.mode = MD_IDX;
                end
                OP_TSX: d.kind = K_TSX;
                OP_TXS: d.kind = K_TXS;
                OP_XGD: d.kind = K_XGD;
                OP_WAI: d.kind = K_WAI;
                OP_TEST: d.kind = test_en ? K_TEST : K_BAD;
                default: d.kind = K_BAD;
            endcase
        end
        case (d.kind)
            K_TST: d.cyc = CYC_TST_MEM;
            K_TSX, K_TXS, K_XGD: d.cyc = CYC_XFER;
            K_SUB_ACC_FIRST_OP, K_SUB_ACC_SECOND_OP, K_SUB_DOUBLE_OP: begin
                case (d.mode)
                    MD_IMM: d.cyc = d.wide ? CYC_IMM16 : CYC_IMM8;
                    MD_DIR: d.cyc = d.wide ? CYC_DIR16 : CYC_DIR8;
                    MD_EXT: d.cyc = d.wide ? CYC_EXT16 : CYC_EXT8;
                    default: d.cyc = d.wide ? CYC_IDX16 : CYC_IDX8;
                endcase
            end
            default: d.cyc = CYC_INH;
        endcase
        // the prefix only pairs with indexed forms and the index transfers
        if (pre && d.mode != MD_IDX && d.kind != K_TSX && d.kind != K_TXS && d.kind != K_XGD) begin
            d.kind = K_BAD;
        end
        d.cyc = d.cyc + {4'h0, pre};
        return d;
    endfunction

    // nzvc of a subtraction from the sign bits and the zero test
    function automatic logic [3:0] csd_nzvc(input logic s, input logic m, input logic r, input logic zero);
        logic v;
        logic c;
        v = (s & ~m & ~r) | (~s & m & r);
        c = (~s & m) | (m & r) | (r & ~s);
        return {r, zero, v, c};
    endfunction

    // stacking order of the wait instruction, one byte per write cycle
    function automatic logic [7:0] csd_push(input logic [4:0] n, input logic [15:0] pc, input logic [15:0] y,
                                            input logic [15:0] x, input logic [7:0] a, input logic [7:0] b,
                                            input logic [7:0] f);
        case (n)
            5'h01: return pc[7:0];
            5'h02: return pc[15:8];
            5'h03: return y[7:0];
            5'h04: return y[15:8];
            5'h05: return x[7:0];
            5'h06: return x[15:8];
            5'h07: return a;
            5'h08: return b;
            default: return f;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    csd_state_e state_q, state_d;
    csd_dec_s dec_q, dec_d;
    logic [4:0] cnt_q, cnt_d;
    logic [15:0] pc_q, pc_d;
    logic [7:0] a_q, a_d;
    logic [7:0] b_q, b_d;
    logic [15:0] ix_q, ix_d;
    logic [15:0] iy_q, iy_d;
    logic [15:0] sp_q, sp_d;
    logic [7:0] ccr_q, ccr_d;
    logic pre_q, pre_d;
    logic [15:0] opnd_q, opnd_d;
    logic [15:0] dat_q, dat_d;
    logic [15:0] tst_q, tst_d;
    logic bad_q, bad_d;
    logic [15:0] rel_q;
    logic [7:0] mask_q;

    csd_ag_if ag ();

    csd_agen u_agen (
        .ag(ag)
    );

    ////////////////////////////////////////////////////////////////////////
    // decode and sequencing terms
    wire csd_dec_s dec_w;
    wire logic [4:0] pos_w;
    wire logic [4:0] nop_w;
    wire logic [4:0] memidx_w;
    wire logic mem_mode_w;
    wire logic rd_now_w;
    wire logic exec_w;
    wire logic push_w;
    wire logic [15:0] cur_w;
    wire logic [15:0] idx_w;
    wire logic [7:0] src8_w;
    wire logic [7:0] sub8_w;
    wire logic [15:0] sub16_w;
    wire logic [3:0] f8_w;
    wire logic [3:0] f16_w;

    assign dec_w = csd_decode(rdata_i, pre_q, test_mode_i);
    // position counted from the opcode byte, after any prefix
    assign pos_w = cnt_q - {4'h0, pre_q};
    // extended address and 16-bit immediate take two operand bytes
    assign nop_w = (dec_q.mode == MD_EXT || (dec_q.mode == MD_IMM && dec_q.wide)) ? 5'h02 : 5'h01;
    assign memidx_w = pos_w - nop_w - 5'h01;
    assign mem_mode_w = dec_q.mode == MD_DIR || dec_q.mode == MD_EXT || dec_q.mode == MD_IDX;
    assign rd_now_w = state_q == ST_OPND || state_q == ST_MEM;
    // the final cycle of an instruction commits its result
    assign exec_w = (rd_now_w || state_q == ST_FILL) && cnt_q == dec_q.cyc - 5'h01;
    assign push_w = state_q == ST_WSTK && cnt_q >= PUSH_FIRST && cnt_q <= PUSH_LAST;
    // last byte read is used in the very cycle it arrives
    assign cur_w = rd_now_w ? {dat_q[7:0], rdata_i} : dat_q;
    assign idx_w = pre_q ? iy_q : ix_q;
    assign src8_w = (dec_q.kind == K_SUB_ACC_SECOND_OP) ? b_q : a_q;
    assign sub8_w = src8_w - cur_w[7:0];
    assign sub16_w = {a_q, b_q} - cur_w;
    assign f8_w = csd_nzvc(src8_w[7], cur_w[7], sub8_w[7], sub8_w == 8'h00);
    assign f16_w = csd_nzvc(a_q[7], cur_w[15], sub16_w[15], sub16_w == 16'h0000);

    // address unit hookup
    assign ag.mode = dec_q.mode;
    assign ag.opnd = opnd_q;
    assign ag.index = idx_w;
    assign ag.second = memidx_w[0];
    assign ag.pc_next = pc_q;
    assign ag.dat = dat_q[7:0];

    ////////////////////////////////////////////////////////////////////////
    // bus drive: opcode/operand at pc, data at ea, pushes at sp
    assign addr_o = (state_q == ST_MEM) ? ag.ea :
                    (state_q == ST_WSTK) ? sp_q :
                    (state_q == ST_VEC) ? VEC_WAI_ADDR + {15'h0000, cnt_q[0]} :
                    (state_q == ST_TEST) ? tst_q :
                    pc_q;
    assign rd_o = state_q == ST_FETCH || rd_now_w || state_q == ST_VEC;
    assign wr_o = push_w;
    assign wdata_o = push_w ? csd_push(cnt_q, pc_q, iy_q, ix_q, a_q, b_q, ccr_q) : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // next state and register updates
    always_comb begin
        state_d = state_q;
        dec_d = dec_q;
        cnt_d = cnt_q + 5'h01;
        pc_d = pc_q;
        a_d = a_q;
        b_d = b_q;
        ix_d = ix_q;
        iy_d = iy_q;
        sp_d = sp_q;
        ccr_d = ccr_q;
        pre_d = pre_q;
        opnd_d = opnd_q;
        dat_d = dat_q;
        tst_d = tst_q;
        bad_d = 1'b0;
        if (rd_now_w || state_q == ST_VEC) begin
            dat_d = {dat_q[7:0], rdata_i};
        end
        case (state_q)
            ST_FETCH: begin
                pc_d = pc_q + 16'h0001;
                if (rdata_i == OP_PREFIX_Y && !pre_q) begin
                    pre_d = 1'b1;
                end else begin
                    dec_d = dec_w;
                    case (dec_w.kind)
                        K_BAD: begin
                            bad_d = 1'b1;
                            pre_d = 1'b0;
                            cnt_d = 5'h00;
                        end
                        K_TEST: begin
                            state_d = ST_TEST;
                            tst_d = pc_q + 16'h0001;
                        end
                        K_WAI: state_d = ST_WSTK;
                        default: state_d = (dec_w.mode == MD_INH) ? ST_FILL : ST_OPND;
                    endcase
                end
            end
            ST_OPND: begin
                pc_d = pc_q + 16'h0001;
                // high byte shifts up as the low byte arrives
                opnd_d = {opnd_q[7:0], rdata_i};
                if (pos_w == nop_w) begin
                    state_d = mem_mode_w ? ST_MEM : ST_FILL;
                end
            end
            ST_MEM: begin
                if (memidx_w == {4'h0, dec_q.wide}) begin
                    state_d = ST_FILL;
                end
            end
            ST_WSTK: begin
                if (push_w) begin
                    sp_d = sp_q - 16'h0001;
                end
                if (cnt_q == CYC_WAI_STACK - 5'h01) begin
                    state_d = ST_WIDLE;
                end
            end
            ST_WIDLE: begin
                // whole idle cycles until the interrupt is recognised
                cnt_d = 5'h00;
                if (irq_i) begin
                    state_d = ST_VEC;
                end
            end
            ST_VEC: begin
                if (cnt_q[0]) begin
                    pc_d = {dat_q[7:0], rdata_i};
                    state_d = ST_FETCH;
                    cnt_d = 5'h00;
                    pre_d = 1'b0;
                end
            end
            ST_TEST: begin
                // no way out but reset; counter frozen to save toggling
                tst_d = tst_q + 16'h0001;
                cnt_d = cnt_q;
            end
            ST_FILL: begin
                cnt_d = cnt_q + 5'h01;
            end
            default: state_d = ST_FETCH;
        endcase
        if (exec_w) begin
            state_d = ST_FETCH;
            cnt_d = 5'h00;
            pre_d = 1'b0;
            case (dec_q.kind)
                K_SUB_ACC_FIRST_OP: begin
                    a_d = sub8_w;
                    ccr_d[FB_N:FB_C] = f8_w;
                end
                K_SUB_ACC_SECOND_OP: begin
                    b_d = sub8_w;
                    ccr_d[FB_N:FB_C] = f8_w;
                end
                K_SUB_DOUBLE_OP: begin
                    {a_d, b_d} = sub16_w;
                    ccr_d[FB_N:FB_C] = f16_w;
                end
                K_TST: ccr_d[FB_N:FB_C] = {cur_w[7], cur_w[7:0] == 8'h00, 2'b00};
                K_ZERO_TEST_ACC_FIRST_OP: ccr_d[FB_N:FB_C] = {a_q[7], a_q == 8'h00, 2'b00};
                K_ZERO_TEST_ACC_SECOND_OP: ccr_d[FB_N:FB_C] = {b_q[7], b_q == 8'h00, 2'b00};
                // x may drop from one to zero, never rise
                K_TAP: ccr_d = {a_q[FB_S], a_q[FB_X] & ccr_q[FB_X], a_q[5:0]};
                K_TPA: a_d = ccr_q;
                K_TSX: begin
                    if (pre_q) begin
                        iy_d = sp_q + 16'h0001;
                    end else begin
                        ix_d = sp_q + 16'h0001;
                    end
                end
                K_TXS: sp_d = idx_w - 16'h0001;
                K_XGD: begin
                    {a_d, b_d} = idx_w;
                    if (pre_q) begin
                        iy_d = {a_q, b_q};
                    end else begin
                        ix_d = {a_q, b_q};
                    end
                end
                default: state_d = ST_FETCH;
            endcase
        end
    end

    // one register bank, synchronous reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_FETCH;
            dec_q <= '0;
            cnt_q <= 5'h00;
            pc_q <= RST_REG16;
            a_q <= RST_ACC;
            b_q <= RST_ACC;
            ix_q <= RST_REG16;
            iy_q <= RST_REG16;
            sp_q <= RST_SP;
            ccr_q <= RST_FLAGS;
            pre_q <= 1'b0;
            opnd_q <= RST_REG16;
            dat_q <= RST_REG16;
            tst_q <= RST_REG16;
            bad_q <= 1'b0;
            rel_q <= RST_REG16;
            mask_q <= RST_ACC;
        end else begin
            state_q <= state_d;
            dec_q <= dec_d;
            cnt_q <= cnt_d;
            pc_q <= pc_d;
            a_q <= a_d;
            b_q <= b_d;
            ix_q <= ix_d;
            iy_q <= iy_d;
            sp_q <= sp_d;
            ccr_q <= ccr_d;
            pre_q <= pre_d;
            opnd_q <= opnd_d;
            dat_q <= dat_d;
            tst_q <= tst_d;
            bad_q <= bad_d;
            rel_q <= ag.rel_target;
            mask_q <= ag.mask_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // visible state
    assign waiting_o = state_q == ST_WIDLE;
    assign testing_o = state_q == ST_TEST;
    assign unsupported_o = bad_q;
    assign pc_o = pc_q;
    assign acc_a_o = a_q;
    assign acc_b_o = b_q;
    assign ix_o = ix_q;
    assign iy_o = iy_q;
    assign sp_o = sp_q;
    assign flags_o = ccr_q;
    assign rel_target_o = rel_q;
    assign mask_set_o = mask_q;

endmodule

`default_nettype wire

// ===== test/csd_core_sva.sv
`timescale 1ns/10ps
`default_nettype none

module csd_core_sva
    import csd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic irq_i,
    input wire logic [15:0] addr_o,
    input wire logic rd_o,
    input wire logic wr_o,
    input wire logic waiting_o,
    input wire logic testing_o,
    input wire logic [7:0] flags_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////
    // test loop: address walks, bus quiet, flags frozen, only reset ends it
    a_test_walk: assert property (testing_o && $past(testing_o) |-> addr_o == $past(addr_o) + 16'h0001)
        else $error("test address did not step");
    a_test_quiet: assert property (testing_o |-> !rd_o && !wr_o)
        else $error("bus active in test loop");
    a_test_flags: assert property (testing_o |=> $stable(flags_o))
        else $error("flags moved in test loop");
    a_test_hold: assert property (testing_o |=> testing_o)
        else $error("test loop ended without reset");
    ////////////////////////////////////////////////////////////////////////
    // wait: 9 pushes, 2 idle, then idle until irq, then two vector reads
    a_wait_flags: assert property (waiting_o |=> $stable(flags_o))
        else $error("flags moved while waiting");
    a_wait_stack: assert property ($rose(waiting_o) |-> $past(wr_o, 3) && !$past(wr_o, 2)
        && $past(wr_o, 11) && !$past(wr_o, 12)) else $error("wait stacking cycles wrong");
    a_wait_vector: assert property (waiting_o && irq_i |=> rd_o && addr_o == VEC_WAI_ADDR
        ##1 rd_o && addr_o == VEC_WAI_ADDR + 16'h0001) else $error("vector fetch wrong");
    a_push_down: assert property (wr_o && $past(wr_o) |-> addr_o == $past(addr_o) - 16'h0001)
        else $error("stack pushes not descending");
    // a flag load may drop the mask bit but never raise it
    a_x_never_set: assert property (!$past(rst_i) && !$past(flags_o[FB_X]) |-> !flags_o[FB_X])
        else $error("mask bit went from zero to one");
endmodule

bind csd_core csd_core_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq_i), .addr_o(addr_o), .rd_o(rd_o),
    .wr_o(wr_o), .waiting_o(waiting_o), .testing_o(testing_o), .flags_o(flags_o));

`default_nettype wire

// ===== test/csd_core_tb.sv
`timescale 1ns/10ps
`default_nettype none

module csd_core_tb;
    import csd_pkg::*;
    logic clk_i;
    logic rst_i;
    logic test_mode_i;
    logic irq_i;
    logic [7:0] rdata_i;
    logic rd_o, wr_o, waiting_o, testing_o, unsupported_o;
    logic [15:0] addr_o, pc_o, ix_o, iy_o, sp_o, rel_target_o;
    logic [7:0] wdata_o, acc_a_o, acc_b_o, flags_o, mask_set_o;
    logic [7:0] mem [0:65535];
    logic [7:0] pushed [$];
    logic [15:0] push_addr [$];
    int errors = 0;
    int num_checks = 0;
    // program: flag load, subtracts, tests, transfers, swap, memory test, wait
    logic [175:0] prog = 176'h06_80_01_06_07_4d_5d_30_18_35_8f_18_30_7d_00_80_c0_01_83_00_01_3e;

    // the core reads memory combinationally in the cycle it drives the address
    assign rdata_i = mem[addr_o];

    csd_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .test_mode_i(test_mode_i), .irq_i(irq_i),
        .rdata_i(rdata_i), .addr_o(addr_o), .rd_o(rd_o), .wr_o(wr_o), .wdata_o(wdata_o),
        .waiting_o(waiting_o), .testing_o(testing_o), .unsupported_o(unsupported_o), .pc_o(pc_o),
        .acc_a_o(acc_a_o), .acc_b_o(acc_b_o), .ix_o(ix_o), .iy_o(iy_o), .sp_o(sp_o), .flags_o(flags_o),
        .rel_target_o(rel_target_o), .mask_set_o(mask_set_o));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // log stacked bytes; writes are not stored so the vector stays intact
    always @(posedge clk_i) begin
        if (wr_o === 1'b1) begin
            pushed.push_back(wdata_o);
            push_addr.push_back(addr_o);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // bounded wait on waiting_o or testing_o; running out ends the run
    task automatic wait_sig(input bit on_test, input logic lvl);
        for (int n = 0; n < 200; n++) begin
            if ((on_test ? testing_o : waiting_o) === lvl) begin
                return;
            end
            @(posedge clk_i);
            #1;
        end
        errors++;
        close_out();
    endtask

    ////////////////////////////////////////////////////////////////////////
    // 38 cycles of instructions, then 12 to reach the wait state
    task automatic t_program();
        logic [71:0] stk;
        stk = 72'h16_00_00_00_00_bf_01_fe_b0;
        repeat (49) @(posedge clk_i);
        #1;
        chk(16'(waiting_o), 16'h0000);
        @(posedge clk_i);
        #1;
        chk(16'(waiting_o), 16'h0001);
        chk({acc_a_o, acc_b_o}, 16'h01fe);
        chk(ix_o, 16'hbf00);
        chk(iy_o, 16'h0000);
        chk(sp_o, 16'hfff6);
        chk(16'(flags_o), 16'h00b0);
        // last operand byte 01 before the wait opcode at 0015, pc then 0016
        chk(rel_target_o, 16'h0017);
        chk(16'(mask_set_o), 16'h0001);
        chk(16'(unsupported_o), 16'h0000);
        chk(16'(pushed.size()), 16'h0009);
        chk(push_addr[0], 16'hffff);
        for (int i = 0; i < 9; i++) begin
            chk(16'(pushed[i]), 16'(stk[71-8*i -: 8]));
        end
        $display("program test done");
    endtask

    // wake by irq, vector to 0040 where the test opcode runs
    task automatic t_wake_test();
        logic [15:0] a;
        repeat (2) @(posedge clk_i);
        irq_i <= 1'b1;
        wait_sig(1'b0, 1'b0);
        @(posedge clk_i);
        irq_i <= 1'b0;
        wait_sig(1'b1, 1'b1);
        chk(16'(flags_o), 16'h00b0);
        a = addr_o;
        repeat (20) begin
            @(posedge clk_i);
            #1;
            chk(addr_o, a + 16'h0001);
            a = addr_o;
        end
        chk(16'(testing_o), 16'h0001);
        $display("wake and test loop done");
    endtask

    task automatic t_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        chk(16'(testing_o), 16'h0000);
        chk(sp_o, RST_SP);
        chk(16'(flags_o), 16'(RST_FLAGS));
        @(posedge clk_i);
        rst_i <= 1'b0;
        $display("reset test done");
    endtask

    initial begin
        rst_i = 1'b1;
        test_mode_i = 1'b1;
        irq_i = 1'b0;
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'h01;
        end
        for (int i = 0; i < 22; i++) begin
            mem[i] = prog[175-8*i -: 8];
        end
        mem[16'h0080] = 8'h80;
        mem[16'hfff0] = 8'h00;
        mem[16'hfff1] = 8'h40;
        mem[16'h0040] = 8'h00;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_program();
        t_wake_test();
        t_reset();
        close_out();
    end
endmodule

`default_nettype wire
